// ===== hw/ctwu_timer.sv
// control timer with two compare/capture channels and waveform outputs
//
// Overview of operation
// - The automatic lock-update setting has no effect at all.
// - In down counting the lock-update bit does not stop period reload from its shadow.
// - A retrigger in the same cycle as a channel compare corrupts that channel's period after the one the retrigger starts.
// - In one-shot DMA mode the overflow DMA trigger is absent in critical dual-ramp modes.
// - Reading a capture value does not clear its flag; a full-width write of one clears it.
`include "ctwu_defines.svh"
`default_nettype none
module ctwu_timer
  import ctwu_pkg::*;
#(
  parameter int W = `CTWU_CNT_W
) (
  input  wire logic                    ref_clk,
  input  wire logic                    arst_n,
  input  wire ctwu_cfg_t               cfg,
  input  wire logic [W-1:0]            period_shadow,
  input  wire logic                    period_shadow_wr,
  input  wire logic [W-1:0]            cmp0_in,
  input  wire logic                    cmp0_wr,
  input  wire logic [W-1:0]            cmp1_in,
  input  wire logic                    cmp1_wr,
  input  wire logic [`CTWU_STAT_W-1:0] stat_clr,
  input  wire logic                    stat_clr_full,
  input  wire logic                    event_in,
  input  wire logic                    dma_done,
  output logic [W-1:0]                 count,
  output logic [W-1:0]                 period_value,
  output ctwu_stat_t                   status,
  output logic [W-1:0]                 channel0_capture_value,
  output logic [W-1:0]                 channel1_capture_value,
  output logic [1:0]                   wave_out,
  output logic                         dma_ovf_req
);

  logic         ev_s1_q;
  logic         ev_s2_q;
  logic         ev_s3_q;
  logic         ev_rise;
  logic [7:0]   div_q;
  logic         tick;
  logic         dual;
  logic         crit;
  logic         retrig_sel;
  logic         retrig_req;
  logic         retrig_q;
  logic         retrig_go;
  logic         cnt_down;
  logic         at_top;
  logic         at_bot;
  logic         boundary;
  logic         cycle_start;
  logic         upd_ok;
  logic         ovf_evt;
  logic         dma_allow;
  logic [W-1:0] cnt_d;
  logic [W-1:0] cnt_q;
  logic [W-1:0] per_q;
  logic [W-1:0] shadow_q;
  logic         shadow_v_q;
  logic         ph_flip;
  ctwu_phase_t  phase_q;
  logic         ovf_q;
  logic         dma_q;
  logic         oneshot_q;
  logic [1:0]   mflag;
  logic [1:0]   wave_w;
  logic [W-1:0] val0;
  logic [W-1:0] val1;
  logic [1:0]   wave_q;
  logic [W-1:0] cap0_q;
  logic [W-1:0] cap1_q;
  logic         clr_ok;

  // event input comes from the asynchronous event path, two flops before use
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ev_s1_q <= 1'b0;
      ev_s2_q <= 1'b0;
      ev_s3_q <= 1'b0;
    end else begin
      ev_s1_q <= event_in;
      ev_s2_q <= ev_s1_q;
      ev_s3_q <= ev_s2_q;
    end
  end
  assign ev_rise = ev_s2_q & ~ev_s3_q;

  // prescaler: divide by 2**divided_clock_sync, one-cycle tick enable
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      div_q <= '0;
    end else if (!cfg.enable || tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end
  // at or past the end value, so a smaller prescaler taken mid-count does not wrap the divider
  assign tick = cfg.enable & (div_q >= (8'((9'h001 << cfg.divided_clock_sync) - 9'h001)));

  // mode decode
  assign dual = cfg.wave[2];
  assign crit = (cfg.wave == CTWU_WAVE_DUAL_C) | (cfg.wave == CTWU_WAVE_DUAL_CS);
  assign retrig_sel = (cfg.event_action_select == `CTWU_EVACT_RETRIG) & ~cfg.capture_mode;
  assign retrig_req = retrig_sel & ev_rise;
  // dual ramps run up and down in phases; the direction bit applies to single ramps
  assign cnt_down = dual ? (phase_q == CTWU_PH_DOWN) : cfg.dir_down;

  // retrigger applied at next tick when synced to divided clock, else next clock
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      retrig_q <= 1'b0;
    end else begin
      retrig_q <= (retrig_q | retrig_req) & ~retrig_go;
    end
  end
  assign retrig_go = (retrig_q | retrig_req) & (~cfg.sync_divided_clock_sync | tick);

  // period boundaries
  assign at_top   = (cnt_q == per_q);
  assign at_bot   = (cnt_q == '0);
  assign boundary = tick & (cnt_down ? at_bot : at_top);
  assign ph_flip  = dual & tick & (phase_q == CTWU_PH_UP ? at_top : at_bot);
  assign cycle_start = retrig_go | (tick & (dual ? (at_bot & phase_q == CTWU_PH_DOWN)
                                                  : boundary));
  assign ovf_evt  = dual ? (tick & at_bot & phase_q == CTWU_PH_DOWN) : boundary;

  // shadow reload permission: lock blocks it when up, never when down; auto lock ignored
  assign upd_ok = ~cfg.buffer_update_lock | cnt_down;

  // next count value
  always_comb begin
    cnt_d = cnt_q;
    if (retrig_go) begin
      cnt_d = cnt_down ? per_q : '0;
    end else if (tick) begin
      if (dual) begin
        cnt_d = (phase_q == CTWU_PH_UP) ? (at_top ? cnt_q - 1'b1 : cnt_q + 1'b1)
                                        : (at_bot ? cnt_q + 1'b1 : cnt_q - 1'b1);
      end else if (cnt_down) begin
        cnt_d = at_bot ? per_q : cnt_q - 1'b1;
      end else begin
        cnt_d = at_top ? '0 : cnt_q + 1'b1;
      end
    end
  end

  // counter, phase, period and its shadow
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q      <= '0;
      phase_q    <= CTWU_PH_UP;
      per_q      <= W'(`CTWU_PER_RST);
      shadow_q   <= W'(`CTWU_PER_RST);
      shadow_v_q <= 1'b0;
    end else begin
      cnt_q <= cfg.enable ? cnt_d : cnt_q;
      if (retrig_go) begin
        phase_q <= CTWU_PH_UP;
      end else if (ph_flip) begin
        phase_q <= (phase_q == CTWU_PH_UP) ? CTWU_PH_DOWN : CTWU_PH_UP;
      end
      if (period_shadow_wr) begin
        shadow_q   <= period_shadow;
        shadow_v_q <= 1'b1;
      end else if (cycle_start && shadow_v_q && upd_ok) begin
        per_q      <= shadow_q;
        shadow_v_q <= 1'b0;
      end
    end
  end

  ctwu_channel #(.W(W)) u_ch0 (
    .ref_clk     (ref_clk),
    .arst_n      (arst_n),
    .tick        (tick),
    .count       (cnt_q),
    .cap_mode    (cfg.capture_mode),
    .cap_evt     (ev_rise),
    .retrig      (retrig_go),
    .cycle_start (cycle_start),
    .cmp_in      (cmp0_in),
    .cmp_wr      (cmp0_wr),
    .flag_clr    (clr_ok & stat_clr[`CTWU_STAT_MC0]),
    .match       (),
    .flag        (mflag[0]),
    .value       (val0),
    .wave_out    (wave_w[0])
  );

  ctwu_channel #(.W(W)) u_ch1 (
    .ref_clk     (ref_clk),
    .arst_n      (arst_n),
    .tick        (tick),
    .count       (cnt_q),
    .cap_mode    (cfg.capture_mode),
    .cap_evt     (ev_rise),
    .retrig      (retrig_go),
    .cycle_start (cycle_start),
    .cmp_in      (cmp1_in),
    .cmp_wr      (cmp1_wr),
    .flag_clr    (clr_ok & stat_clr[`CTWU_STAT_MC1]),
    .match       (),
    .flag        (mflag[1]),
    .value       (val1),
    .wave_out    (wave_w[1])
  );

  // only full-width status clears take effect; narrow ones are dropped
  assign clr_ok = stat_clr_full;

  // one-shot dma: no overflow request in critical dual ramps when one-shot is set
  assign dma_allow = ~(cfg.dma_one_shot_select & dual & crit);

  // overflow flag, dma request and registered outputs
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ovf_q     <= 1'b0;
      dma_q     <= 1'b0;
      oneshot_q <= 1'b0;
      wave_q    <= 2'h0;
      cap0_q    <= '0;
      cap1_q    <= '0;
    end else begin
      ovf_q <= ovf_evt | (ovf_q & ~(clr_ok & stat_clr[`CTWU_STAT_OVF]));
      if (ovf_evt && dma_allow && !(cfg.dma_one_shot_select && oneshot_q)) begin
        dma_q     <= 1'b1;
        oneshot_q <= cfg.dma_one_shot_select;
      end else if (dma_done) begin
        dma_q     <= 1'b0;
        oneshot_q <= 1'b0;
      end
      wave_q <= wave_w;
      cap0_q <= val0;
      cap1_q <= val1;
    end
  end

  assign count                  = cnt_q;
  assign period_value           = per_q;
  assign status                 = '{counter_overflow: ovf_q, channel1_match_flag: mflag[1],
                                    channel0_match_flag: mflag[0]};
  assign channel0_capture_value = cap0_q;
  assign channel1_capture_value = cap1_q;
  assign wave_out               = wave_q;
  assign dma_ovf_req            = dma_q;

endmodule : ctwu_timer
`default_nettype wire

// ===== hw/ctwu_defines.svh
// constants for the control timer waveform unit
`ifndef CTWU_DEFINES_SVH
`define CTWU_DEFINES_SVH

`define CTWU_CNT_W        16
`define CTWU_PER_RST      16'hffff
`define CTWU_EVACT_RETRIG 3'h1
`define CTWU_DIVIDED_CLOCK_SYNC_W      3
`define CTWU_STAT_MC0     0
`define CTWU_STAT_MC1     1
`define CTWU_STAT_OVF     2
`define CTWU_STAT_W       3

`endif

// ===== hw/ctwu_pkg.sv
// types for the control timer waveform unit
`default_nettype none
package ctwu_pkg;

  // waveform generation modes
  typedef enum logic [2:0] {
    CTWU_WAVE_NFRQ    = 3'b000,
    CTWU_WAVE_NPWM    = 3'b010,
    CTWU_WAVE_DUAL    = 3'b100,
    CTWU_WAVE_DUAL_A  = 3'b101,
    CTWU_WAVE_DUAL_C  = 3'b110,
    CTWU_WAVE_DUAL_CS = 3'b111
  } ctwu_wave_t;

  // counter phase within a dual ramp period
  typedef enum logic [0:0] {
    CTWU_PH_UP   = 1'b0,
    CTWU_PH_DOWN = 1'b1
  } ctwu_phase_t;

  // static configuration carried as one group
  typedef struct packed {
    logic        enable;
    ctwu_wave_t  wave;
    logic [2:0]  divided_clock_sync;
    logic        sync_divided_clock_sync;
    logic        dir_down;
    logic        buffer_update_lock;
    logic        auto_update_lock;
    logic        dma_one_shot_select;
    logic        dither_en;
    logic        capture_mode;
    logic [2:0]  event_action_select;
  } ctwu_cfg_t;

  // status flags
  typedef struct packed {
    logic counter_overflow;
    logic channel1_match_flag;
    logic channel0_match_flag;
  } ctwu_stat_t;

endpackage : ctwu_pkg
`default_nettype wire

// ===== hw/ctwu_channel.sv
// one compare/capture channel of the control timer
`default_nettype none
module ctwu_channel
  import ctwu_pkg::*;
#(
  parameter int W = 16
) (
  input  wire logic         ref_clk,
  input  wire logic         arst_n,
  input  wire logic         tick,
  input  wire logic [W-1:0] count,
  input  wire logic         cap_mode,
  input  wire logic         cap_evt,
  input  wire logic         retrig,
  input  wire logic         cycle_start,
  input  wire logic [W-1:0] cmp_in,
  input  wire logic         cmp_wr,
  input  wire logic         flag_clr,
  output logic              match,
  output logic              flag,
  output logic [W-1:0]      value,
  output logic              wave_out
);

  logic         hit;
  logic         corrupt_d;
  logic         corrupt_q;
  logic [W-1:0] value_q;
  logic         flag_q;
  logic         wave_q;

  // compare hit while the counter advances
  assign hit   = tick & ~cap_mode & (count == value_q);
  assign match = hit | (cap_mode & cap_evt);
  // a retrigger landing on a compare hit spoils the period after the one it starts
  assign corrupt_d = (hit & retrig) ? 1'b1 : (cycle_start ? 1'b0 : corrupt_q);

  // compare value or captured count
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      value_q <= '0;
    end else if (cap_mode && cap_evt) begin
      value_q <= count;
    end else if (cmp_wr) begin
      value_q <= cmp_in;
    end
  end

  // sticky flag: set wins over clear, a read never clears it
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= match | (flag_q & ~flag_clr);
    end
  end

  // waveform: high from period start until compare; corrupted period holds low
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wave_q    <= 1'b0;
      corrupt_q <= 1'b0;
    end else begin
      corrupt_q <= corrupt_d;
      if (cycle_start) begin
        wave_q <= ~corrupt_q;
      end else if (hit) begin
        wave_q <= 1'b0;
      end
    end
  end

  assign flag     = flag_q;
  assign value    = value_q;
  assign wave_out = wave_q;

endmodule : ctwu_channel
`default_nettype wire

// ===== bench/ctwu_sva.sv
// port assertions for the control timer
`include "ctwu_defines.svh"
`default_nettype none
module ctwu_sva
  import ctwu_pkg::*;
#(
  parameter int W = 16
) (
  input wire logic                    ref_clk,
  input wire logic                    arst_n,
  input wire ctwu_cfg_t               cfg,
  input wire logic [`CTWU_STAT_W-1:0] stat_clr,
  input wire logic                    stat_clr_full,
  input wire logic                    dma_done,
  input wire logic [W-1:0]            period_value,
  input wire ctwu_stat_t              status,
  input wire logic                    dma_ovf_req
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // match flags only fall through a full-width write of one
  mc0_clear_a: assert property (
    $fell(status.channel0_match_flag) |-> $past(stat_clr[0] && stat_clr_full))
    else $error("mc0 flag fell without clear");
  mc1_clear_a: assert property (
    $fell(status.channel1_match_flag) |-> $past(stat_clr[1] && stat_clr_full))
    else $error("mc1 flag fell without clear");
  // narrow writes leave overflow standing
  ovf_keep_a: assert property (
    status.counter_overflow && !(stat_clr[2] && stat_clr_full) |=> status.counter_overflow)
    else $error("overflow flag dropped");
  // no overflow dma in critical dual modes with one-shot
  dma_crit_a: assert property (
    $rose(dma_ovf_req) |-> !($past(cfg.dma_one_shot_select) &&
      ($past(cfg.wave) inside {CTWU_WAVE_DUAL_C, CTWU_WAVE_DUAL_CS})))
    else $error("overflow dma in critical mode");
  dma_hold_a: assert property (
    dma_ovf_req && !dma_done |=> dma_ovf_req)
    else $error("dma request dropped early");
  // lock holds the period only when counting up
  lock_up_a: assert property (
    cfg.buffer_update_lock && !cfg.dir_down && !cfg.wave[2] |=> $stable(period_value))
    else $error("period reloaded while locked");
  // main scenarios
  cover property ($rose(dma_ovf_req));
  cover property ($fell(status.channel0_match_flag));
  cover property (cfg.dir_down && cfg.buffer_update_lock ##1 $changed(period_value));
endmodule : ctwu_sva
bind ctwu_timer ctwu_sva #(.W(W)) ctwu_sva_i (.ref_clk(ref_clk), .arst_n(arst_n), .cfg(cfg),
  .stat_clr(stat_clr), .stat_clr_full(stat_clr_full), .dma_done(dma_done),
  .period_value(period_value), .status(status), .dma_ovf_req(dma_ovf_req));
`default_nettype wire

// ===== bench/ctwu_partner.sv
// far side model: event channel and dma responder
`default_nettype none
module ctwu_partner (
  input  wire logic ref_clk,
  input  wire logic arst_n,
  input  wire logic ev_req,
  input  wire logic slow,
  input  wire logic dma_ovf_req,
  output logic      event_in,
  output logic      dma_done
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] wait_q;
  // asynchronous channel: level passes with no resync stage
  assign #1.3 event_in = ev_req;
  // dma takes each request once, after a short or long wait
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wait_q   <= 4'h0;
      dma_done <= 1'b0;
    end else begin
      dma_done <= 1'b0;
      if (dma_ovf_req && !dma_done) begin
        wait_q <= wait_q + 4'h1;
        if (wait_q == (slow ? 4'h9 : 4'h1)) begin
          dma_done <= 1'b1;
          wait_q   <= 4'h0;
        end
      end
    end
  end
endmodule : ctwu_partner
`default_nettype wire

// ===== bench/testbench.sv
// self-checking bench for the control timer
`include "ctwu_defines.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import ctwu_pkg::*;
  localparam int W = 8;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  ctwu_cfg_t cfg = '0;
  logic [W-1:0] period_shadow = '0;
  logic [W-1:0] count, period_value, v;
  logic [W-1:0] cap0, cap1;
  logic [W-1:0] cmp0_in = '0;
  logic [W-1:0] cmp1_in = '0;
  logic [1:0] wave_o;
  logic cmp_wr = 1'b0;
  logic [2:0] stat_clr = '0;
  logic period_shadow_wr = 1'b0;
  logic stat_clr_full = 1'b0;
  logic ev_req = 1'b0;
  logic slow = 1'b0;
  logic req_d = 1'b0;
  logic event_in, dma_done, dma_ovf_req;
  ctwu_stat_t status;
  int miscompares = 0;
  int n_tests = 0;
  int n_rise = 0;
  int seed = 32'h22166909;
  ctwu_wave_t waves [5] = '{CTWU_WAVE_NPWM, CTWU_WAVE_DUAL, CTWU_WAVE_DUAL_A,
                            CTWU_WAVE_DUAL_C, CTWU_WAVE_DUAL_CS};

  ctwu_timer #(.W(W)) ctwu_timer_i (.ref_clk(ref_clk), .arst_n(arst_n), .cfg(cfg),
    .period_shadow(period_shadow), .period_shadow_wr(period_shadow_wr), .cmp0_in(cmp0_in),
    .cmp0_wr(cmp_wr), .cmp1_in(cmp1_in), .cmp1_wr(cmp_wr), .stat_clr(stat_clr),
    .stat_clr_full(stat_clr_full), .event_in(event_in), .dma_done(dma_done), .count(count),
    .period_value(period_value), .status(status), .channel0_capture_value(cap0),
    .channel1_capture_value(cap1), .wave_out(wave_o), .dma_ovf_req(dma_ovf_req));
  ctwu_partner ctwu_partner_i (.ref_clk(ref_clk), .arst_n(arst_n), .ev_req(ev_req),
    .slow(slow), .dma_ovf_req(dma_ovf_req), .event_in(event_in), .dma_done(dma_done));

  // clock and dma request edge counter
  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (dma_ovf_req && !req_d) n_rise++;
    req_d <= dma_ovf_req;
  end

  // next count of an up-counting single slope
  function automatic logic [W-1:0] nxt(input logic [W-1:0] c, input logic [W-1:0] p);
    return (c == p) ? '0 : c + 1'b1;
  endfunction : nxt
  // overflow dma expected unless one-shot critical dual mode
  function automatic logic exp_dma(input ctwu_wave_t wv);
    return !(wv inside {CTWU_WAVE_DUAL_C, CTWU_WAVE_DUAL_CS});
  endfunction : exp_dma
  // both waveforms early in a period; channel 0 spoiled in the period after the one its retrigger starts
  function automatic logic [7:0] exp_wave(input int k);
    return (k == 1) ? 8'h02 : 8'h03;
  endfunction : exp_wave

  task automatic chk(input logic [W-1:0] got, input logic [W-1:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc
  task automatic set_per(input logic [W-1:0] p);
    int i;
    @(posedge ref_clk);
    period_shadow    <= p;
    period_shadow_wr <= 1'b1;
    @(posedge ref_clk);
    period_shadow_wr <= 1'b0;
    for (i = 0; i < 600 && period_value !== p; i++) @(posedge ref_clk);
    #1;
  endtask : set_per
  task automatic clr(input logic [2:0] b, input logic full);
    @(posedge ref_clk);
    stat_clr      <= b;
    stat_clr_full <= full;
    @(posedge ref_clk);
    stat_clr <= 3'h0;
    #1;
  endtask : clr
  task automatic stop_test;
    $display("tests %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test

  // watchdog
  initial begin
    cyc(20000);
    miscompares++;
    stop_test();
  end

  // main sequence
  initial begin
    int i;
    int k;
    logic [W-1:0] c;
    cyc(20);
    arst_n <= 1'b1;
    #1;
    chk(period_value, '1);
    chk(8'(status), 8'h00);
    @(posedge ref_clk);
    cfg.enable           <= 1'b1;
    cfg.wave             <= CTWU_WAVE_NPWM;
    cfg.auto_update_lock <= 1'b1;
    set_per(8'h03);
    chk(period_value, 8'h03);
    for (i = 0; i < 8; i++) begin
      c = count;
      @(posedge ref_clk);
      #1;
      chk(count, nxt(c, 8'h03));
    end
    chk(8'(status.counter_overflow), 8'h01);
    @(posedge ref_clk);
    cfg.enable <= 1'b0;
    clr(3'h7, 1'b0);
    chk(8'(status.counter_overflow), 8'h01);
    clr(3'h7, 1'b1);
    chk(8'(status), 8'h00);
    v = 8'(4 + ($random(seed) & 7));
    @(posedge ref_clk);
    cfg.enable             <= 1'b1;
    cfg.buffer_update_lock <= 1'b1;
    set_per(v);
    chk(period_value, 8'h03);
    cfg.dir_down <= 1'b1;
    set_per(v);
    chk(period_value, v);
    cfg.buffer_update_lock  <= 1'b0;
    cfg.dir_down            <= 1'b0;
    cfg.dma_one_shot_select <= 1'b1;
    set_per(8'h03);
    for (i = 0; i < 5; i++) begin
      @(posedge ref_clk);
      cfg.wave <= waves[i];
      slow     <= 1'(($random(seed) >> 4) & 1);
      cyc(3);
      #1;
      n_rise = 0;
      cyc(40);
      chk(8'(n_rise != 0), 8'(exp_dma(waves[i])));
    end
    cfg.wave                <= CTWU_WAVE_NPWM;
    cfg.dma_one_shot_select <= 1'b0;
    cfg.capture_mode        <= 1'b1;
    cfg.enable              <= 1'b0; // frozen count gives a known capture value
    clr(3'h7, 1'b1);
    @(posedge ref_clk);
    ev_req <= 1'b1;
    cyc(8);
    ev_req <= 1'b0;
    cyc(10);
    #1;
    chk(8'(status.channel0_match_flag), 8'h01);
    c = count;
    chk(cap0, c);
    chk(cap1, c);
    clr(3'h1, 1'b1);
    chk(8'(status.channel0_match_flag), 8'h00);
    chk(8'(status.channel1_match_flag), 8'h01);
    @(posedge ref_clk);
    cfg.capture_mode        <= 1'b0;
    cfg.enable              <= 1'b1;
    cfg.dither_en           <= 1'b0;
    cfg.event_action_select <= `CTWU_EVACT_RETRIG;
    cfg.divided_clock_sync               <= 3'h1;
    cfg.sync_divided_clock_sync          <= 1'b1;
    set_per(8'h30);
    for (i = 0; i < 600 && count !== 8'h20; i++) @(posedge ref_clk);
    ev_req <= 1'b1;
    cyc(12);
    #1;
    chk(8'(count < 8'h10), 8'h01);
    // retrigger landing on the channel 0 compare, channel 1 untouched
    @(posedge ref_clk);
    ev_req         <= 1'b0;
    cfg.divided_clock_sync      <= 3'h0;
    cfg.sync_divided_clock_sync <= 1'b0;
    cmp0_in        <= 8'h13;
    cmp1_in        <= 8'h08;
    cmp_wr         <= 1'b1;
    @(posedge ref_clk);
    cmp_wr <= 1'b0;
    for (i = 0; i < 600; i++) begin
      @(posedge ref_clk);
      if (count === 8'h10) break;
    end
    ev_req <= 1'b1; // three edges in, the count stands at the compare value
    for (k = 0; k < 3; k++) begin
      for (i = 0; i < 600; i++) begin
        @(posedge ref_clk);
        if (count === 8'h04) break;
      end
      #1;
      chk(8'(wave_o), exp_wave(k));
    end
    stop_test();
  end
endmodule : testbench
`default_nettype wire
